// ### src/serial_flash_command_front_end.sv
// Purpose: Command front end of a serial NOR flash: framing, lane modes, reads, protection
// Assumes: sclk from host, csn high between frames, array read port answers rdAddr at once
// Notes:   Frame results cross to mclk by a toggle and a word held until the next frame
// Behaviour
// - Bottom select: levels 1-9 protect lowest blocks
// - Levels 10-15 protect all 512 blocks
// - Top select: levels 1-9 protect highest blocks
// - Security bit 0 reports factory lock
// - Secured mode redirects programming to OTP area
// - Write-security command sets customer lock bit 1
// - Locked OTP ranges refuse any further change
// - Secured mode blocks main array access
// - OTP: 000-1FF customer, 200-3FF factory range
// - Unknown command: standby, output high impedance
// - Valid command stays active until csn rises
// - Sample rising, drive falling; modes 0 and 3
// - Reads may end after any output bit
// - Writes and mode changes need byte-aligned end
// - Busy device ignores array accesses
// - All addresses are four bytes
// - Opcode 35h enters four-lane command mode
// - Opcode F5h returns to single-lane commands
// - 03 no dummy, 0B dummy, single-lane data
// - BB dual address and data, 3B dual data
// - EB quad in both modes, 6B single only
// - Dummy count follows configuration bits 6 and 7
module serial_flash_command_front_end (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        sclk,
	input  wire logic        csn,
	input  wire logic [3:0]  ioIn,
	output logic      [3:0]  ioOut,
	output logic      [3:0]  ioOen,
	output logic      [31:0] rdAddr,
	output logic             rdOtp,
	input  wire logic [7:0]  rdData,
	input  wire logic [3:0]  protectLevel,
	input  wire logic        bottomProtect,
	input  wire logic [1:0]  dummyCfg,
	input  wire logic        factoryLock,
	input  wire logic        busy,
	output logic      [1:0]  securityReg,
	output logic             quadModeStatus,
	output logic             securedStatus,
	output logic             writeReq,
	output logic             eraseReq,
	output logic      [31:0] reqAddr,
	output logic      [7:0]  reqData,
	output logic             reqOtp,
	output logic             refused
);
	// Frame-edge domain: persistent modes and the committed command
	logic                quadModeReg;
	logic                securedReg;
	logic                commitTglReg;
	sflash_pkg::commit_t commitReg;

	// Link domain, rising edge
	sflash_pkg::phase_t phaseReg;
	logic [7:0]         opReg;
	logic [31:0]        shReg;
	logic [5:0]         cntReg;
	logic [2:0]         bitPosReg;
	logic [31:0]        addrReg;
	logic [7:0]         wdataReg;
	logic               doneReg;
	logic [2:0]         addrLanesReg;
	logic [2:0]         dataLanesReg;
	logic [5:0]         dummyReg;
	logic               ddrReg;
	logic [3:0]         ddrLoOutReg;
	logic [1:0]         dcSync1Reg;
	logic [1:0]         dcSync2Reg;
	logic               busyLink1Reg;
	logic               busyLink2Reg;

	// Link domain, falling edge
	logic [3:0]  outReg;
	logic [3:0]  oenReg;
	logic [7:0]  outShReg;
	logic [2:0]  outCntReg;
	logic        startedReg;
	logic [31:0] rdPtrReg;
	logic [3:0]  ddrLoNibReg;

	// Link decode
	logic [2:0]  cmdLanes;
	logic [2:0]  curLanes;
	logic [31:0] shNext;
	logic [7:0]  opNext;
	logic [5:0]  cmdLast;
	logic [5:0]  addrLast;
	logic        isRead;
	logic        isAddrWrite;
	logic        isSimple;
	logic        opValid;
	logic [2:0]  opAddrLanes;
	logic [2:0]  opDataLanes;
	logic [5:0]  dcCount;
	logic        commitOk;

	assign cmdLanes = quadModeReg ? sflash_pkg::LANES_4 : sflash_pkg::LANES_1;
	assign curLanes = (phaseReg == sflash_pkg::PH_ADDR) ? addrLanesReg : cmdLanes;
	assign shNext   = (curLanes == sflash_pkg::LANES_4) ? {shReg[27:0], ioIn} :
	                  (curLanes == sflash_pkg::LANES_2) ? {shReg[29:0], ioIn[1:0]} :
	                  {shReg[30:0], ioIn[0]};
	assign opNext   = shNext[7:0];
	assign cmdLast  = quadModeReg ? 6'h01 : 6'h07;
	assign addrLast = (addrLanesReg == sflash_pkg::LANES_4) ? 6'h07 :
	                  (addrLanesReg == sflash_pkg::LANES_2) ? 6'h0F : 6'h1F;

	assign isRead = (!quadModeReg && (opNext == sflash_pkg::OP_READ || opNext == sflash_pkg::OP_FAST ||
	                  opNext == sflash_pkg::OP_DUAL_IO || opNext == sflash_pkg::OP_DUAL_OUT ||
	                  opNext == sflash_pkg::OP_QUAD_OUT)) ||
	                opNext == sflash_pkg::OP_QUAD_IO || opNext == sflash_pkg::OP_QUAD_DDR;
	assign isAddrWrite = opNext == sflash_pkg::OP_PROGRAM || opNext == sflash_pkg::OP_ERASE_SECT ||
	                     opNext == sflash_pkg::OP_ERASE_BLK;
	assign isSimple = (!quadModeReg && opNext == sflash_pkg::OP_ENTER_QUAD) ||
	                  (quadModeReg && opNext == sflash_pkg::OP_EXIT_QUAD) ||
	                  opNext == sflash_pkg::OP_ENTER_SEC || opNext == sflash_pkg::OP_EXIT_SEC ||
	                  opNext == sflash_pkg::OP_WR_SEC;
	// Reads are refused while an internal write runs
	assign opValid = (isRead && !busyLink2Reg) || isAddrWrite || isSimple;

	assign opAddrLanes = (quadModeReg || opNext == sflash_pkg::OP_QUAD_IO || opNext == sflash_pkg::OP_QUAD_DDR) ?
	                     sflash_pkg::LANES_4 :
	                     (opNext == sflash_pkg::OP_DUAL_IO) ? sflash_pkg::LANES_2 : sflash_pkg::LANES_1;
	assign opDataLanes = (quadModeReg || opNext == sflash_pkg::OP_QUAD_IO || opNext == sflash_pkg::OP_QUAD_OUT ||
	                      opNext == sflash_pkg::OP_QUAD_DDR) ? sflash_pkg::LANES_4 :
	                     (opNext == sflash_pkg::OP_DUAL_IO || opNext == sflash_pkg::OP_DUAL_OUT) ?
	                     sflash_pkg::LANES_2 : sflash_pkg::LANES_1;
	assign dcCount = (dcSync2Reg == 2'h0) ? sflash_pkg::DUMMY_DC0 :
	                 (dcSync2Reg == 2'h1) ? sflash_pkg::DUMMY_DC1 :
	                 (dcSync2Reg == 2'h2) ? sflash_pkg::DUMMY_DC2 : sflash_pkg::DUMMY_DC3;
	assign commitOk = doneReg && bitPosReg == 3'h0;

	// Synchronisers into the link domain; valid after two clocks of a frame
	always_ff @(posedge sclk) begin
		dcSync1Reg   <= dummyCfg;
		dcSync2Reg   <= dcSync1Reg;
		busyLink1Reg <= busy;
		busyLink2Reg <= busyLink1Reg;
	end

	// Input sampling on rising edges; frame state cleared while csn is high
	always_ff @(posedge sclk or posedge csn) begin
		if (csn) begin
			phaseReg     <= sflash_pkg::PH_CMD;
			opReg        <= 8'h00;
			shReg        <= 32'h0000_0000;
			cntReg       <= 6'h00;
			bitPosReg    <= 3'h0;
			addrReg      <= 32'h0000_0000;
			wdataReg     <= 8'h00;
			doneReg      <= 1'b0;
			addrLanesReg <= sflash_pkg::LANES_1;
			dataLanesReg <= sflash_pkg::LANES_1;
			dummyReg     <= 6'h00;
			ddrReg       <= 1'b0;
		end else begin
			shReg     <= shNext;
			bitPosReg <= bitPosReg + curLanes;
			cntReg    <= cntReg + 6'h01;
			unique case (phaseReg)
				sflash_pkg::PH_CMD: begin
					if (cntReg == cmdLast) begin
						cntReg       <= 6'h00;
						opReg        <= opNext;
						addrLanesReg <= opAddrLanes;
						dataLanesReg <= opDataLanes;
						ddrReg       <= opNext == sflash_pkg::OP_QUAD_DDR;
						dummyReg     <= (opNext == sflash_pkg::OP_READ) ? 6'h00 : dcCount;
						if (!opValid)
							phaseReg <= sflash_pkg::PH_STANDBY;
						else if (isSimple) begin
							phaseReg <= sflash_pkg::PH_HOLD;
							doneReg  <= 1'b1;
						end else
							phaseReg <= sflash_pkg::PH_ADDR;
					end
				end
				sflash_pkg::PH_ADDR: begin
					if (cntReg == addrLast) begin
						cntReg  <= 6'h00;
						addrReg <= shNext;
						if (opReg == sflash_pkg::OP_PROGRAM)
							phaseReg <= sflash_pkg::PH_WDATA;
						else if (opReg == sflash_pkg::OP_ERASE_SECT || opReg == sflash_pkg::OP_ERASE_BLK) begin
							phaseReg <= sflash_pkg::PH_HOLD;
							doneReg  <= 1'b1;
						end else if (dummyReg == 6'h00)
							phaseReg <= sflash_pkg::PH_DATA;
						else
							phaseReg <= sflash_pkg::PH_DUMMY;
					end
				end
				sflash_pkg::PH_DUMMY: begin
					if (cntReg == dummyReg - 6'h01)
						phaseReg <= sflash_pkg::PH_DATA;
				end
				sflash_pkg::PH_WDATA: begin
					if (bitPosReg + curLanes == 3'h0) begin
						wdataReg <= shNext[7:0];
						doneReg  <= 1'b1;
					end
				end
				sflash_pkg::PH_DATA,
				sflash_pkg::PH_HOLD,
				sflash_pkg::PH_STANDBY: begin
				end
			endcase
		end
	end

	// Output driving on falling edges; reads may stop after any bit
	always_ff @(negedge sclk or posedge csn) begin
		if (csn) begin
			outReg      <= 4'h0;
			oenReg      <= 4'hF;
			outShReg    <= 8'h00;
			outCntReg   <= 3'h0;
			startedReg  <= 1'b0;
			rdPtrReg    <= 32'h0000_0000;
			ddrLoNibReg <= 4'h0;
		end else if (phaseReg == sflash_pkg::PH_DATA) begin
			if (outCntReg == 3'h0 || ddrReg) begin
				startedReg <= 1'b1;
				rdPtrReg   <= rdAddr + 32'h0000_0001;
				if (dataLanesReg == sflash_pkg::LANES_4) begin
					outReg      <= rdData[7:4];
					oenReg      <= 4'h0;
					outShReg    <= {rdData[3:0], 4'h0};
					ddrLoNibReg <= rdData[3:0];
					outCntReg   <= ddrReg ? 3'h0 : 3'h4;
				end else if (dataLanesReg == sflash_pkg::LANES_2) begin
					outReg    <= {2'h0, rdData[7:6]};
					oenReg    <= 4'hC;
					outShReg  <= {rdData[5:0], 2'h0};
					outCntReg <= 3'h6;
				end else begin
					outReg    <= {2'h0, rdData[7], 1'b0};
					oenReg    <= 4'hD;
					outShReg  <= {rdData[6:0], 1'b0};
					outCntReg <= 3'h7;
				end
			end else if (dataLanesReg == sflash_pkg::LANES_4) begin
				outReg    <= outShReg[7:4];
				outShReg  <= {outShReg[3:0], 4'h0};
				outCntReg <= outCntReg - 3'h4;
			end else if (dataLanesReg == sflash_pkg::LANES_2) begin
				outReg    <= {2'h0, outShReg[7:6]};
				outShReg  <= {outShReg[5:0], 2'h0};
				outCntReg <= outCntReg - 3'h2;
			end else begin
				outReg    <= {2'h0, outShReg[7], 1'b0};
				outShReg  <= {outShReg[6:0], 1'b0};
				outCntReg <= outCntReg - 3'h1;
			end
		end else begin
			oenReg <= 4'hF;
		end
	end

	// Second half of each double-rate byte, launched on the rising edge
	always_ff @(posedge sclk or posedge csn) begin
		if (csn)
			ddrLoOutReg <= 4'h0;
		else
			ddrLoOutReg <= ddrLoNibReg;
	end

	assign ioOut  = (ddrReg && sclk && startedReg) ? ddrLoOutReg : outReg;
	assign ioOen  = oenReg;
	assign rdAddr = startedReg ? rdPtrReg : addrReg;
	assign rdOtp  = securedReg;

	// Frame end: modes change and commands commit only on a byte boundary
	always_ff @(posedge csn or negedge rstn) begin
		if (!rstn) begin
			quadModeReg  <= 1'b0;
			securedReg   <= 1'b0;
			commitTglReg <= 1'b0;
			commitReg    <= '0;
		end else if (commitOk) begin
			if (opReg == sflash_pkg::OP_ENTER_QUAD)
				quadModeReg <= 1'b1;
			else if (opReg == sflash_pkg::OP_EXIT_QUAD)
				quadModeReg <= 1'b0;
			else if (opReg == sflash_pkg::OP_ENTER_SEC)
				securedReg <= 1'b1;
			else if (opReg == sflash_pkg::OP_EXIT_SEC)
				securedReg <= 1'b0;
			else begin
				commitTglReg      <= ~commitTglReg;
				commitReg.secured <= securedReg;
				commitReg.addr    <= addrReg;
				commitReg.data    <= wdataReg;
				commitReg.kind    <= (opReg == sflash_pkg::OP_PROGRAM) ? sflash_pkg::KIND_PROGRAM :
				                     (opReg == sflash_pkg::OP_WR_SEC) ? sflash_pkg::KIND_LOCK :
				                     sflash_pkg::KIND_ERASE;
			end
		end
	end

	// System clock side
	logic       tglS1Reg;
	logic       tglS2Reg;
	logic       tglS3Reg;
	logic [1:0] modeS1Reg;
	logic [1:0] modeS2Reg;
	logic       customerLockReg;
	logic       commitEvent;
	logic [9:0] blockIdx;
	logic [9:0] levelSpan;
	logic       inBottom;
	logic       inTop;
	logic       arrayLocked;
	logic [9:0] otpOffset;
	logic       otpLocked;

	assign commitEvent = tglS2Reg ^ tglS3Reg;
	assign blockIdx    = {1'b0, commitReg.addr[sflash_pkg::BLOCK_MSB:sflash_pkg::BLOCK_LSB]};
	assign levelSpan   = 10'h001 << (protectLevel - 4'h1);
	assign inBottom    = blockIdx < levelSpan;
	assign inTop       = blockIdx >= sflash_pkg::BLOCK_COUNT - levelSpan;
	assign arrayLocked = protectLevel >= sflash_pkg::LEVEL_ALL ||
	                     (protectLevel != 4'h0 && (bottomProtect ? inBottom : inTop));
	assign otpOffset   = commitReg.addr[9:0];
	assign otpLocked   = (otpOffset >= sflash_pkg::OTP_FACTORY) ? factoryLock : customerLockReg;

	always_ff @(posedge mclk) begin
		tglS1Reg  <= commitTglReg;
		tglS2Reg  <= tglS1Reg;
		modeS1Reg <= {quadModeReg, securedReg};
		modeS2Reg <= modeS1Reg;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tglS3Reg        <= 1'b0;
			customerLockReg <= 1'b0;
			writeReq        <= 1'b0;
			eraseReq        <= 1'b0;
			reqAddr         <= 32'h0000_0000;
			reqData         <= 8'h00;
			reqOtp          <= 1'b0;
			refused         <= 1'b0;
			quadModeStatus  <= 1'b0;
			securedStatus   <= 1'b0;
			securityReg     <= 2'h0;
		end else begin
			tglS3Reg       <= tglS2Reg;
			quadModeStatus <= modeS2Reg[1];
			securedStatus  <= modeS2Reg[0];
			securityReg[sflash_pkg::SEC_FACTORY]  <= factoryLock;
			securityReg[sflash_pkg::SEC_CUSTOMER] <= customerLockReg;
			writeReq <= 1'b0;
			eraseReq <= 1'b0;
			refused  <= 1'b0;
			if (commitEvent) begin
				reqAddr <= commitReg.addr;
				reqData <= commitReg.data;
				reqOtp  <= commitReg.secured;
				unique case (commitReg.kind)
					sflash_pkg::KIND_PROGRAM: begin
						if (busy || (commitReg.secured ? otpLocked : arrayLocked))
							refused <= 1'b1;
						else
							writeReq <= 1'b1;
					end
					sflash_pkg::KIND_ERASE: begin
						if (busy || commitReg.secured || arrayLocked)
							refused <= 1'b1;
						else
							eraseReq <= 1'b1;
					end
					sflash_pkg::KIND_LOCK: begin
						customerLockReg <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule : serial_flash_command_front_end

// ### src/sflash_pkg.sv
// Purpose: Shared constants and types for the serial flash command front end
// Assumes: 32-bit addresses, 64KB blocks, 1KB one-time-programmable area
// Notes:   Opcodes without a printed value are local picks
package sflash_pkg;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST       = 8'h0B;
	localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
	localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
	localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
	localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
	localparam logic [7:0] OP_QUAD_DDR   = 8'hED;
	localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
	localparam logic [7:0] OP_EXIT_QUAD  = 8'hF5;
	localparam logic [7:0] OP_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_ERASE_SECT = 8'h20;
	localparam logic [7:0] OP_ERASE_BLK  = 8'hD8;
	localparam logic [7:0] OP_ENTER_SEC  = 8'hB1;
	localparam logic [7:0] OP_EXIT_SEC   = 8'hC1;
	localparam logic [7:0] OP_WR_SEC     = 8'h2F;

	localparam logic [1:0] KIND_NONE    = 2'h0;
	localparam logic [1:0] KIND_PROGRAM = 2'h1;
	localparam logic [1:0] KIND_ERASE   = 2'h2;
	localparam logic [1:0] KIND_LOCK    = 2'h3;

	localparam int         BLOCK_LSB      = 16;
	localparam int         BLOCK_MSB      = 24;
	localparam logic [9:0] BLOCK_COUNT    = 10'h200;
	localparam logic [3:0] LEVEL_ALL      = 4'hA;
	localparam logic [9:0] OTP_FACTORY    = 10'h200;
	localparam int         SEC_FACTORY    = 0;
	localparam int         SEC_CUSTOMER   = 1;
	localparam logic [2:0] LANES_1        = 3'h1;
	localparam logic [2:0] LANES_2        = 3'h2;
	localparam logic [2:0] LANES_4        = 3'h4;
	localparam logic [5:0] DUMMY_DC0      = 6'h08;
	localparam logic [5:0] DUMMY_DC1      = 6'h06;
	localparam logic [5:0] DUMMY_DC2      = 6'h08;
	localparam logic [5:0] DUMMY_DC3      = 6'h0A;

	typedef enum logic [6:0] {
		PH_CMD     = 7'h01,
		PH_ADDR    = 7'h02,
		PH_DUMMY   = 7'h04,
		PH_DATA    = 7'h08,
		PH_WDATA   = 7'h10,
		PH_HOLD    = 7'h20,
		PH_STANDBY = 7'h40
	} phase_t;

	typedef struct packed {
		logic [1:0]  kind;
		logic        secured;
		logic [31:0] addr;
		logic [7:0]  data;
	} commit_t;
endpackage : sflash_pkg

// ### sim/sflash_checker.sv
// Purpose: Port-level checks of the flash command front end
// Assumes: mclk domain; protect inputs stay stable around commits
// Notes:   Bound to the design module below
module sflash_checker (
	input logic        mclk,
	input logic        rstn,
	input logic        csn,
	input logic [3:0]  ioOen,
	input logic [3:0]  protectLevel,
	input logic        bottomProtect,
	input logic        factoryLock,
	input logic        busy,
	input logic [1:0]  securityReg,
	input logic        quadModeStatus,
	input logic        securedStatus,
	input logic        writeReq,
	input logic        eraseReq,
	input logic [31:0] reqAddr,
	input logic        reqOtp,
	input logic        refused
);
	logic [3:0] busyRun;
	logic [8:0] lim;
	logic       mainReq;
	logic       inBand;
	assign lim     = 9'h001 << (protectLevel - 4'h1);
	assign mainReq = (writeReq | eraseReq) & ~reqOtp;
	assign inBand  = (protectLevel != 4'h0) && (protectLevel < 4'hA);
	always_ff @(posedge mclk) begin
		if (!rstn || !busy) busyRun <= 4'h0;
		else if (busyRun != 4'hF) busyRun <= busyRun + 4'h1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	idle_release_a: assert property (csn && $past(csn) |-> ioOen == 4'hF)
		else $error("lanes enabled while deselected");
	all_protect_a: assert property (mainReq |-> protectLevel < 4'hA)
		else $error("commit while all blocks protected");
	bottom_protect_a: assert property (mainReq && inBand && bottomProtect |-> reqAddr[24:16] >= lim)
		else $error("commit into protected low block");
	top_protect_a: assert property (mainReq && inBand && !bottomProtect |-> (~reqAddr[24:16]) >= lim)
		else $error("commit into protected high block");
	otp_lock_a: assert property (writeReq && reqOtp |-> !(securityReg[0] && reqAddr[9]) &&
		!(securityReg[1] && !reqAddr[9]))
		else $error("program into locked otp range");
	busy_block_a: assert property (writeReq || eraseReq |-> busyRun < 4'h8)
		else $error("commit accepted while busy");
	secured_erase_a: assert property (eraseReq |-> !securedStatus)
		else $error("erase accepted in secured mode");
	otp_route_a: assert property (writeReq |-> reqOtp == securedStatus)
		else $error("program not routed by secured mode");
	factory_bit_a: assert property ($rose(factoryLock) |-> ##[1:3] securityReg[0])
		else $error("factory lock not reported");
	cust_hold_a: assert property (securityReg[1] |=> securityReg[1])
		else $error("customer lock cleared");
	cover property (writeReq && reqOtp);
	cover property (refused);
	cover property (quadModeStatus && !csn);
endmodule : sflash_checker

bind serial_flash_command_front_end sflash_checker i_chk (.mclk(mclk), .rstn(rstn), .csn(csn), .ioOen(ioOen),
	.protectLevel(protectLevel), .bottomProtect(bottomProtect), .factoryLock(factoryLock), .busy(busy),
	.securityReg(securityReg), .quadModeStatus(quadModeStatus), .securedStatus(securedStatus),
	.writeReq(writeReq), .eraseReq(eraseReq), .reqAddr(reqAddr), .reqOtp(reqOtp), .refused(refused));

// ### sim/sflash_host.sv
// Purpose: Host flash controller model, serial modes 0 and 3
// Assumes: sclk stands at its idle level between frames, 15 ns period
// Notes:   Lanes show the inverse of the last value when released
module sflash_host (
	output logic       sclk,
	output logic       csn,
	output logic [3:0] ioDrv,
	input  logic [3:0] ioOut,
	input  logic [3:0] ioOen
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] outSeen;
	logic [3:0] oenSeen;
	logic [3:0] lateSeen;
	logic       idleHigh;
	initial begin
		idleHigh = 1'b0;
		sclk = 1'b0;
		csn = 1'b1;
		ioDrv = 4'h5;
	end
	// Fall, data set while low, taken on the rise; output read before it
	// Double-rate second nibble read while high
	task automatic tick(input logic [3:0] v);
		sclk = 1'b0;
		ioDrv = v;
		#7.5;
		outSeen = ioOut;
		oenSeen = ioOen;
		sclk = 1'b1;
		#7.5;
		lateSeen = ioOut;
	endtask : tick
	// Idle level between frames: low for mode 0, high for mode 3
	task automatic set_idle(input logic hi);
		#15;
		idleHigh = hi;
		sclk = hi;
	endtask : set_idle
	task automatic shift(input logic [31:0] v, input int bits, input int lanes);
		for (int i = bits; i > 0; i -= lanes) tick(4'((v >> (i - lanes)) & ((32'h1 << lanes) - 32'h1)));
	endtask : shift
	// Whole frame; csn rises half a period after the last rise, on a byte boundary only when the bits sent fill whole bytes
	task automatic frame(input logic [7:0] op, input int opL, input logic [31:0] ad, input int adL,
		input int dum, input logic [7:0] wd, input int wBits, input int rdL, input int nBytes,
		output logic [31:0] rx, output logic drv, output logic ok);
		logic [3:0] mask;
		mask = (rdL == 1) ? 4'h2 : 4'((32'h1 << rdL) - 32'h1);
		rx = 32'h0;
		drv = 1'b0;
		ok = 1'b1;
		#15;
		csn = 1'b0;
		shift({24'h0, op}, 8, opL);
		if (adL > 0) shift(ad, 32, adL);
		repeat (dum) tick(~ioDrv);
		if (wBits > 0) shift({24'h0, wd} >> (8 - wBits), wBits, 1);
		repeat (nBytes * 8 / rdL) begin
			tick(~ioDrv);
			drv |= (oenSeen != 4'hF);
			ok &= ((oenSeen & mask) == 4'h0);
			rx = (rx << rdL) | 32'((rdL == 1) ? {3'h0, outSeen[1]} :
			                       (rdL == 8) ? {outSeen, lateSeen} : (outSeen & mask));
		end
		if (!idleHigh) sclk = 1'b0;
		csn = 1'b1;
		ioDrv = ~ioDrv;
	endtask : frame
endmodule : sflash_host

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the flash command front end
// Assumes: Host model drives the link; array data follows the read address
// Notes:   Commit outcome 0 none, 1 program, 2 erase, 3 refused; eight data lanes mark double rate
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] BASE = 32'h0012_34FE;
	logic        mclk, rstn, sclk, csn, rdOtp, bottomProtect, factoryLock, busy;
	logic        quadModeStatus, securedStatus, writeReq, eraseReq, reqOtp, refused;
	logic [3:0]  ioDrv, ioIn, ioOut, ioOen, protectLevel;
	logic [31:0] rdAddr, reqAddr;
	logic [7:0]  rdData, reqData;
	logic [1:0]  dummyCfg, securityReg;
	int          num_errors, compares, lim, blk, want;
	logic [7:0]  rdOps [8] = '{sflash_pkg::OP_READ, sflash_pkg::OP_FAST, sflash_pkg::OP_DUAL_IO,
		sflash_pkg::OP_DUAL_OUT, sflash_pkg::OP_QUAD_IO, sflash_pkg::OP_QUAD_OUT, 8'h05, sflash_pkg::OP_QUAD_DDR};
	int          adLanes [8] = '{1, 1, 2, 1, 4, 1, 1, 4};
	int          dLanes [8] = '{1, 1, 2, 2, 4, 4, 1, 8};
	logic [5:0]  dumTab [4] = '{sflash_pkg::DUMMY_DC0, sflash_pkg::DUMMY_DC1, sflash_pkg::DUMMY_DC2,
		sflash_pkg::DUMMY_DC3};
	always #5 mclk = ~mclk;
	assign ioIn = (ioOut & ~ioOen) | (ioDrv & ioOen);
	assign rdData = rdAddr[7:0] ^ (rdOtp ? 8'hA5 : 8'h00);
	sflash_host i_host (.sclk(sclk), .csn(csn), .ioDrv(ioDrv), .ioOut(ioOut), .ioOen(ioOen));
	serial_flash_command_front_end i_dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .csn(csn), .ioIn(ioIn),
		.ioOut(ioOut), .ioOen(ioOen), .rdAddr(rdAddr), .rdOtp(rdOtp), .rdData(rdData),
		.protectLevel(protectLevel), .bottomProtect(bottomProtect), .dummyCfg(dummyCfg),
		.factoryLock(factoryLock), .busy(busy), .securityReg(securityReg), .quadModeStatus(quadModeStatus),
		.securedStatus(securedStatus), .writeReq(writeReq), .eraseReq(eraseReq), .reqAddr(reqAddr),
		.reqData(reqData), .reqOtp(reqOtp), .refused(refused));
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check
	task automatic rd(input int k, input int opL, input int dum, input logic otp, input logic expOk);
		logic [31:0] rx, exp;
		logic        drv, ok;
		for (int n = 0; n < 4; n++) exp = {exp[23:0], 8'(BASE + n) ^ (otp ? 8'hA5 : 8'h00)};
		i_host.frame(rdOps[k], opL, BASE, adLanes[k], dum, 8'h00, 0, dLanes[k], 4, rx, drv, ok);
		if (expOk) check(rx === exp && ok === 1'b1, "read data");
		else check(drv === 1'b0, "standby lanes driven");
	endtask : rd
	task automatic wr(input logic [7:0] op, input int opL, input logic [31:0] a, input int wb, input int exp);
		logic [31:0] rx;
		logic        drv, ok;
		int          got, adL;
		adL = (op == sflash_pkg::OP_PROGRAM || op == sflash_pkg::OP_ERASE_SECT) ? 1 : 0;
		i_host.frame(op, opL, a, adL, 0, a[7:0] ^ 8'h3C, wb, 1, 0, rx, drv, ok);
		got = 0;
		repeat (12) begin
			@(posedge mclk);
			#1;
			if (writeReq === 1'b1 && reqData === (a[7:0] ^ 8'h3C) && reqAddr === a) got = 1;
			if (eraseReq === 1'b1) got = 2;
			if (refused === 1'b1) got = 3;
		end
		check(got == exp, "commit outcome");
	endtask : wr
	task automatic print_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		protectLevel = 4'h0;
		bottomProtect = 1'b0;
		dummyCfg = 2'h0;
		factoryLock = 1'b0;
		busy = 1'b0;
		num_errors = 0;
		compares = 0;
		repeat (2) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge mclk);
		for (int k = 0; k < 6; k++) rd(k, 1, (k == 0) ? 0 : dumTab[0], 1'b0, 1'b1);
		rd(6, 1, 0, 1'b0, 1'b0);
		rd(7, 1, dumTab[0], 1'b0, 1'b1);
		for (int d = 1; d < 4; d++) begin
			@(posedge mclk);
			#1 dummyCfg = 2'(d);
			rd(1, 1, dumTab[d], 1'b0, 1'b1);
		end
		i_host.set_idle(1'b1);
		rd(0, 1, 0, 1'b0, 1'b1);
		rd(2, 1, dumTab[3], 1'b0, 1'b1);
		i_host.set_idle(1'b0);
		$display("read tests done");
		wr(sflash_pkg::OP_ENTER_QUAD, 1, 32'h0, 1, 0);
		check(quadModeStatus === 1'b0, "off-boundary mode change");
		wr(sflash_pkg::OP_ENTER_QUAD, 1, 32'h0, 0, 0);
		check(quadModeStatus === 1'b1, "quad mode entry");
		rd(4, 4, dumTab[3], 1'b0, 1'b1);
		rd(7, 4, dumTab[3], 1'b0, 1'b1);
		rd(5, 4, dumTab[3], 1'b0, 1'b0);
		wr(sflash_pkg::OP_EXIT_QUAD, 4, 32'h0, 0, 0);
		check(quadModeStatus === 1'b0, "quad mode exit");
		$display("mode tests done");
		wr(sflash_pkg::OP_ERASE_SECT, 1, 32'h0005_0000, 0, 2);
		wr(sflash_pkg::OP_PROGRAM, 1, 32'h0006_0010, 7, 0);
		busy = 1'b1;
		wr(sflash_pkg::OP_PROGRAM, 1, 32'h0006_0010, 8, 3);
		rd(1, 1, dumTab[3], 1'b0, 1'b0);
		busy = 1'b0;
		for (int lv = 0; lv < 16; lv++) begin
			for (int bt = 0; bt < 2; bt++) begin
				@(posedge mclk);
				#1 protectLevel = 4'(lv);
				bottomProtect = bt[0];
				lim = (lv == 0) ? 0 : ((lv >= 10) ? 512 : (1 << (lv - 1)));
				for (int j = 0; j < 4; j++) begin
					blk = ((j == 0) ? lim - 1 : (j == 1) ? lim : (j == 2) ? 512 - lim : 511 - lim) & 511;
					want = (lv >= 10 || (lv != 0 && (bt != 0 ? blk < lim : blk >= 512 - lim))) ? 3 : 1;
					wr(sflash_pkg::OP_PROGRAM, 1, {7'h0, 9'(blk), 16'h0123}, 8, want);
				end
			end
		end
		$display("protection tests done");
		@(posedge mclk);
		#1 factoryLock = 1'b1;
		protectLevel = 4'h0;
		wr(sflash_pkg::OP_ENTER_SEC, 1, 32'h0, 0, 0);
		check(securedStatus === 1'b1 && securityReg === 2'h1, "secured entry");
		rd(0, 1, 0, 1'b1, 1'b1);
		wr(sflash_pkg::OP_PROGRAM, 1, 32'h0000_01FF, 8, 1);
		wr(sflash_pkg::OP_PROGRAM, 1, 32'h0000_0200, 8, 3);
		wr(sflash_pkg::OP_ERASE_SECT, 1, 32'h0005_0000, 0, 3);
		wr(sflash_pkg::OP_WR_SEC, 1, 32'h0, 0, 0);
		check(securityReg === 2'h3, "customer lock");
		wr(sflash_pkg::OP_PROGRAM, 1, 32'h0000_0010, 8, 3);
		wr(sflash_pkg::OP_EXIT_SEC, 1, 32'h0, 0, 0);
		check(securedStatus === 1'b0, "secured exit");
		$display("secured tests done");
		print_verdict();
	end
endmodule : tb_top
